//--- verilog/psir_pkg.sv
package psir_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [4:0]  REG_STATUS_SUMMARY      = 5'h19;
	localparam logic [4:0]  REG_INTERRUPT_CTRL_STAT = 5'h1a;
	localparam logic [4:0]  REG_AUX_MODE_TWO        = 5'h1b;

	// ----------------------------------------
	// Interrupt register fields and reset
	// ----------------------------------------
	localparam int          IRQ_RSVD15_BIT       = 15;
	localparam int          IRQ_ON_BIT           = 14;
	localparam int          IRQ_DUPLEX_MASK_BIT  = 11;
	localparam int          IRQ_SPEED_MASK_BIT   = 10;
	localparam int          IRQ_LINK_MASK_BIT    = 9;
	localparam int          IRQ_MASTER_MASK_BIT  = 8;
	localparam logic [15:0] IRQ_RESET            = 16'h0f00;

	// ----------------------------------------
	// Mode 2 fields and reset
	// ----------------------------------------
	localparam int          MODE2_TRUNCATE_BIT   = 11;
	localparam int          MODE2_TXC_INV_BIT    = 8;
	localparam int          MODE2_ECHO_BLOCK_BIT = 7;
	localparam int          MODE2_QUAL_PD_BIT    = 1;
	localparam logic [15:0] MODE2_WRITABLE       = 16'h0ffe;
	localparam logic [15:0] MODE2_RESET          = 16'h008a;

	// ----------------------------------------
	// Management frame
	// ----------------------------------------
	localparam logic [5:0]  MDIO_PREAMBLE_LEN = 6'h20;
	localparam logic [3:0]  MDIO_HDR_LAST     = 4'hc;
	localparam logic [3:0]  MDIO_DATA_LAST    = 4'hf;
	localparam logic [1:0]  MDIO_OP_READ      = 2'h2;
	localparam logic [1:0]  MDIO_OP_WRITE     = 2'h1;

	typedef enum logic [1:0]
	{
		MS_PRE  = 2'h0,
		MS_HDR  = 2'h1,
		MS_TA   = 2'h3,
		MS_DATA = 2'h2
	} psir_mdio_state_t;

	function automatic logic psir_is_local(input logic [4:0] addr);
		return (addr == REG_STATUS_SUMMARY) || (addr == REG_INTERRUPT_CTRL_STAT)
			|| (addr == REG_AUX_MODE_TWO);
	endfunction

endpackage

//--- verilog/psir_mgmt_if.sv
`timescale 1ns/1ps
interface psir_mgmt_if;
	logic        rd_stb;
	logic        wr_stb;
	logic [4:0]  addr;
	logic [15:0] wdata;
	logic [15:0] rdata;

	modport serial_side
	(
		output rd_stb,
		output wr_stb,
		output addr,
		output wdata,
		input  rdata
	);

	modport reg_side
	(
		input  rd_stb,
		input  wr_stb,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface

//--- verilog/psir_mdio_slave.sv
`timescale 1ns/1ps
module psir_mdio_slave
	import psir_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01
)
(
	input  wire logic   clk_sys,
	input  wire logic   sys_rst,
	input  wire logic   mdc,
	input  wire logic   mdio_in,
	output logic        mdio_out,
	output logic        mdio_oe,
	psir_mgmt_if.serial_side bus
);

	// ----------------------------------------
	// Pin synchronisers, level taken once stages two and three agree
	// ----------------------------------------
	logic [2:0] mdc_sync;
	logic [2:0] mdio_sync;
	logic       mdc_level;
	logic       mdio_level;
	logic       mdc_rise;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			mdc_sync   <= 3'h0;
			mdio_sync  <= 3'h0;
			mdc_level  <= 1'b0;
			mdio_level <= 1'b0;
		end
		else
		begin
			mdc_sync  <= {mdc_sync[1:0], mdc};
			mdio_sync <= {mdio_sync[1:0], mdio_in};
			if (mdc_sync[1] == mdc_sync[2])
				mdc_level <= mdc_sync[2];
			if (mdio_sync[1] == mdio_sync[2])
				mdio_level <= mdio_sync[2];
		end
	end

	// MDIO settles long before MDC rises, so its filtered level is stable here
	assign mdc_rise = (mdc_sync[1] == mdc_sync[2]) && mdc_sync[2] && !mdc_level;

	// ----------------------------------------
	// Frame decoder
	// ----------------------------------------
	psir_mdio_state_t state;
	logic [5:0]       pre_cnt;
	logic [3:0]       bit_cnt;
	logic [11:0]      hdr;
	logic [15:0]      shift;
	logic             is_read;
	logic             rd_pend;
	logic [12:0]      hdr_full;

	assign hdr_full = {hdr, mdio_level};

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state     <= MS_PRE;
			pre_cnt   <= 6'h00;
			bit_cnt   <= 4'h0;
			hdr       <= 12'h000;
			shift     <= 16'h0000;
			is_read   <= 1'b0;
			rd_pend   <= 1'b0;
			mdio_out  <= 1'b0;
			mdio_oe   <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.wr_stb <= 1'b0;
			bus.addr  <= 5'h00;
			bus.wdata <= 16'h0000;
		end
		else
		begin
			bus.rd_stb <= rd_pend;
			bus.wr_stb <= 1'b0;
			rd_pend    <= 1'b0;
			if (bus.rd_stb)
				shift <= bus.rdata;
			if (mdc_rise)
			begin
				unique case (state)
					MS_PRE:
					begin
						if (mdio_level)
						begin
							if (pre_cnt != MDIO_PREAMBLE_LEN)
								pre_cnt <= pre_cnt + 6'h01;
						end
						else if (pre_cnt == MDIO_PREAMBLE_LEN)
						begin
							state   <= MS_HDR;
							bit_cnt <= 4'h0;
						end
						else
							pre_cnt <= 6'h00;
					end
					MS_HDR:
					begin
						hdr     <= hdr_full[11:0];
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == MDIO_HDR_LAST)
						begin
							pre_cnt <= 6'h00;
							bit_cnt <= 4'h0;
							if (hdr_full[12] && hdr_full[9:5] == PHY_ADDR
								&& psir_is_local(hdr_full[4:0])
								&& (hdr_full[11:10] == MDIO_OP_READ
								|| hdr_full[11:10] == MDIO_OP_WRITE))
							begin
								state    <= MS_TA;
								bus.addr <= hdr_full[4:0];
								is_read  <= (hdr_full[11:10] == MDIO_OP_READ);
								rd_pend  <= (hdr_full[11:10] == MDIO_OP_READ);
							end
							else
								state <= MS_PRE;
						end
					end
					MS_TA:
					begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == 4'h0)
						begin
							mdio_oe  <= is_read;
							mdio_out <= 1'b0;
						end
						else
						begin
							state   <= MS_DATA;
							bit_cnt <= 4'h0;
							if (is_read)
							begin
								mdio_out <= shift[15];
								shift    <= {shift[14:0], 1'b0};
							end
						end
					end
					MS_DATA:
					begin
						bit_cnt <= bit_cnt + 4'h1;
						if (is_read)
						begin
							mdio_out <= shift[15];
							shift    <= {shift[14:0], 1'b0};
						end
						else
							shift <= {shift[14:0], mdio_level};
						if (bit_cnt == MDIO_DATA_LAST)
						begin
							state   <= MS_PRE;
							mdio_oe <= 1'b0;
							if (!is_read)
							begin
								bus.wr_stb <= 1'b1;
								bus.wdata  <= {shift[14:0], mdio_level};
							end
						end
					end
				endcase
			end
		end
	end

endmodule

//--- verilog/psir_datapath.sv
`timescale 1ns/1ps
module psir_datapath
(
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic suppress_tx_echo,
	input  wire logic nibble_truncate_on,
	input  wire logic tx_clock_invert,
	input  wire logic qual_pd_on,
	input  wire logic is_10bt_half,
	input  wire logic tx_en,
	input  wire logic rx_dv_raw,
	input  wire logic rx_partial_nibble,
	input  wire logic crs_raw,
	input  wire logic tx_clk_in,
	input  wire logic legacy_partner,
	input  wire logic pd_link_raw,
	input  wire logic pd_speed_100,
	input  wire logic adv_10,
	input  wire logic adv_100,
	input  wire logic an_link_raw,
	output logic      rx_dv,
	output logic      crs,
	output logic      txc_out,
	output logic      link_ok
);

	// ----------------------------------------
	// Transmit clock path
	// ----------------------------------------
	logic [2:0] txc_sync;
	logic       txc_level;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			txc_sync  <= 3'h0;
			txc_level <= 1'b0;
			txc_out   <= 1'b0;
		end
		else
		begin
			txc_sync <= {txc_sync[1:0], tx_clk_in};
			if (txc_sync[1] == txc_sync[2])
				txc_level <= txc_sync[2];
			txc_out <= txc_level ^ tx_clock_invert; // RULE_14
		end
	end

	// ----------------------------------------
	// Receive echo, carrier and link
	// ----------------------------------------
	logic speed_advertised;
	logic tail_block;

	assign speed_advertised = pd_speed_100 ? adv_100 : adv_10;

	// Own echo lingering after transmit ends is kept off carrier until it clears
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			tail_block <= 1'h0;
		else
			tail_block <= tx_en || (tail_block && crs_raw); // RULE_15
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rx_dv   <= 1'b0;
			crs     <= 1'b0;
			link_ok <= 1'b0;
		end
		else
		begin
			// Partial trailing nibble is dropped rather than passed with stale bits
			rx_dv <= rx_dv_raw && !(nibble_truncate_on && rx_partial_nibble) // RULE_13
				|| (is_10bt_half && tx_en && !suppress_tx_echo); // RULE_15
			if (is_10bt_half && suppress_tx_echo)
				crs <= tx_en || (crs_raw && !tail_block); // RULE_15
			else
				crs <= crs_raw || (is_10bt_half && tx_en);
			if (legacy_partner)
				link_ok <= pd_link_raw && (!qual_pd_on || speed_advertised); // RULE_16 RULE_17
			else
				link_ok <= an_link_raw;
		end
	end

endmodule

//--- verilog/psir_top.sv
// Behaviour
// RULE_01 - Read-only summary register mirrors status held in other registers.
// RULE_02 - Summary bits 10:8 report negotiated best mode code, 11x undefined.
// RULE_03 - Latched-high bits hold one, latched-low hold zero, until read.
// RULE_04 - Summary bit 2 shows link pass, latched low until read.
// RULE_05 - Summary bit 1 shows auto-negotiation enabled, following the enable pin.
// RULE_06 - Summary bit 0 latches jabber, bit 5 latches new page received.
// RULE_07 - Summary bit 11 shows resolved pause, bit 3 shows 100 Mbps speed.
// RULE_08 - Interrupt bit 14 turns the interrupt function on; reset clears it.
// RULE_09 - Duplex, speed, link masks (bits 11..9, default one) suppress change interrupts.
// RULE_10 - Master mask bit 8 blocks the hardware interrupt regardless of others.
// RULE_11 - Interrupt bits 3..1 latch duplex, speed, link changes; read clears.
// RULE_12 - Interrupt bit 0 mirrors the interrupt pin; read clears it.
// RULE_13 - Mode 2 bit 11 truncates received 10BASE-T dribble to whole nibble.
// RULE_14 - Mode 2 bit 8 inverts the transmit clock.
// RULE_15 - Mode 2 bit 7 blocks transmit echo on receive valid, carrier follows.
// RULE_16 - Without qualification, legacy partners link regardless of advertisement.
// RULE_17 - Mode 2 bit 1 links only at an advertised detected speed.
// RULE_18 - Software writes reserved bits with their default values.
// RULE_19 - Duplex, speed, link compared with previous cycle to detect changes.
`timescale 1ns/1ps
module psir_top
	import psir_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01
)
(
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe,
	output logic            irq_out,
	input  wire logic       autoneg_enable_pin,
	input  wire logic       an_enable_ctrl,
	input  wire logic       an_complete,
	input  wire logic       an_ack_complete_evt,
	input  wire logic       an_ack_detect_evt,
	input  wire logic       an_ability_evt,
	input  wire logic       an_pause,
	input  wire logic [2:0] negotiated_best_mode,
	input  wire logic       pd_fault_evt,
	input  wire logic       lp_remote_fault,
	input  wire logic       page_rx_evt,
	input  wire logic       lp_an_able,
	input  wire logic       jabber_evt,
	input  wire logic       speed_100,
	input  wire logic       duplex_full,
	input  wire logic       is_10bt_half,
	input  wire logic       tx_en,
	input  wire logic       rx_dv_raw,
	input  wire logic       rx_partial_nibble,
	input  wire logic       crs_raw,
	input  wire logic       tx_clk_in,
	input  wire logic       legacy_partner,
	input  wire logic       pd_link_raw,
	input  wire logic       pd_speed_100,
	input  wire logic       adv_10,
	input  wire logic       adv_100,
	input  wire logic       an_link_raw,
	output logic            rx_dv,
	output logic            crs,
	output logic            txc_out,
	output logic            link_ok
);

	// ----------------------------------------
	// Management access
	// ----------------------------------------
	psir_mgmt_if mgmt ();

	psir_mdio_slave #(
		.PHY_ADDR (PHY_ADDR)
	) u_mdio (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.bus      (mgmt.serial_side)
	);

	// ----------------------------------------
	// Register strobes
	// ----------------------------------------

	logic rd_summary;
	logic rd_irq;
	logic wr_irq;
	logic wr_mode2;

	assign rd_summary = mgmt.rd_stb && mgmt.addr == REG_STATUS_SUMMARY;
	assign rd_irq     = mgmt.rd_stb && mgmt.addr == REG_INTERRUPT_CTRL_STAT;
	assign wr_irq     = mgmt.wr_stb && mgmt.addr == REG_INTERRUPT_CTRL_STAT;
	assign wr_mode2   = mgmt.wr_stb && mgmt.addr == REG_AUX_MODE_TWO;

	// ----------------------------------------
	// Enable pin synchroniser
	// ----------------------------------------
	logic [2:0] autoneg_enable_pin_sync;
	logic       autoneg_enable_pin_level;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			autoneg_enable_pin_sync  <= 3'h0;
			autoneg_enable_pin_level <= 1'b0;
		end
		else
		begin
			autoneg_enable_pin_sync <= {autoneg_enable_pin_sync[1:0], autoneg_enable_pin};
			if (autoneg_enable_pin_sync[1] == autoneg_enable_pin_sync[2])
				autoneg_enable_pin_level <= autoneg_enable_pin_sync[2];
		end
	end

	// ----------------------------------------
	// Mode 2 register
	// ----------------------------------------
	logic [15:0] aux_mode_two;

	// Bits outside MODE2_WRITABLE are stored as zero; software keeps reserved bits at defaults
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			aux_mode_two <= MODE2_RESET;
		else if (wr_mode2)
			aux_mode_two <= mgmt.wdata & MODE2_WRITABLE; // RULE_18
	end

	psir_datapath u_dp (
		.clk_sys            (clk_sys),
		.sys_rst            (sys_rst),
		.suppress_tx_echo   (aux_mode_two[MODE2_ECHO_BLOCK_BIT]),
		.nibble_truncate_on (aux_mode_two[MODE2_TRUNCATE_BIT]),
		.tx_clock_invert    (aux_mode_two[MODE2_TXC_INV_BIT]),
		.qual_pd_on         (aux_mode_two[MODE2_QUAL_PD_BIT]),
		.is_10bt_half       (is_10bt_half),
		.tx_en              (tx_en),
		.rx_dv_raw          (rx_dv_raw),
		.rx_partial_nibble  (rx_partial_nibble),
		.crs_raw            (crs_raw),
		.tx_clk_in          (tx_clk_in),
		.legacy_partner     (legacy_partner),
		.pd_link_raw        (pd_link_raw),
		.pd_speed_100       (pd_speed_100),
		.adv_10             (adv_10),
		.adv_100            (adv_100),
		.an_link_raw        (an_link_raw),
		.rx_dv              (rx_dv),
		.crs                (crs),
		.txc_out            (txc_out),
		.link_ok            (link_ok)
	);

	// ----------------------------------------
	// Read clear helper
	// ----------------------------------------

	// A fresh event wins over a read clear in the same cycle
	function automatic logic psir_latch_hi(input logic held, input logic clr, input logic evt);
		return (held && !clr) || evt;
	endfunction

	// ----------------------------------------
	// Summary latches
	// ----------------------------------------
	logic [4:0] lh_flags;
	logic       link_lost;

	// An event in the same cycle as the read survives the clear
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			lh_flags  <= 5'h00;
			link_lost <= 1'b0;
		end
		else
		begin
			lh_flags  <= (lh_flags & {5{!rd_summary}}) // RULE_03
				| {an_ack_complete_evt, an_ack_detect_evt, an_ability_evt,
				pd_fault_evt, jabber_evt}; // RULE_06
			link_lost <= psir_latch_hi(link_lost, rd_summary, !link_ok); // RULE_04
		end
	end

	// ----------------------------------------
	// Summary word
	// ----------------------------------------

	logic        page_rx_latched;
	logic [15:0] status_summary;

	always_comb
	begin
		status_summary        = 16'h0000; // RULE_01
		status_summary[15]    = an_complete;
		status_summary[14:12] = lh_flags[4:2];
		status_summary[11]    = an_pause; // RULE_07
		status_summary[10:8]  = negotiated_best_mode; // RULE_02
		status_summary[7]     = lh_flags[1];
		status_summary[6]     = lp_remote_fault;
		status_summary[5]     = page_rx_latched; // RULE_06
		status_summary[4]     = lp_an_able;
		status_summary[3]     = speed_100; // RULE_07
		status_summary[2]     = link_ok && !link_lost; // RULE_04
		status_summary[1]     = autoneg_enable_pin_level && an_enable_ctrl; // RULE_05
		status_summary[0]     = lh_flags[0]; // RULE_06
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			page_rx_latched <= 1'b0;
		else
			page_rx_latched <= psir_latch_hi(page_rx_latched, rd_summary, page_rx_evt); // RULE_03
	end

	// ----------------------------------------
	// Interrupt register
	// ----------------------------------------
	logic [15:8] irq_ctrl;
	logic [2:0]  prev_state;
	logic [2:0]  change_flags;
	logic [2:0]  next_change_flags;
	logic [2:0]  change_now;
	logic        irq_pending;
	logic        next_irq_pending;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			irq_ctrl <= IRQ_RESET[15:8];
		else if (wr_irq)
			irq_ctrl <= mgmt.wdata[15:8] & 8'hcf; // RULE_08
	end

	// ----------------------------------------
	// Change detection
	// ----------------------------------------

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			prev_state <= 3'h0;
		else
			prev_state <= {duplex_full, speed_100, link_ok}; // RULE_19
	end

	assign change_now = prev_state ^ {duplex_full, speed_100, link_ok}; // RULE_19

	// ----------------------------------------
	// Change flags
	// ----------------------------------------

	always_comb
	begin
		next_change_flags = (change_flags & {3{!rd_irq}}) // RULE_11
			| (change_now & {3{irq_ctrl[IRQ_ON_BIT]}} // RULE_08
			& ~{irq_ctrl[IRQ_DUPLEX_MASK_BIT], irq_ctrl[IRQ_SPEED_MASK_BIT],
			irq_ctrl[IRQ_LINK_MASK_BIT]}); // RULE_09
		next_irq_pending = irq_ctrl[IRQ_ON_BIT] && !irq_ctrl[IRQ_MASTER_MASK_BIT] // RULE_10
			&& (|next_change_flags); // RULE_12
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			change_flags <= 3'h0;
			irq_pending  <= 1'b0;
		end
		else
		begin
			change_flags <= next_change_flags; // RULE_11
			irq_pending  <= next_irq_pending; // RULE_12
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------

	// Pin and status bit share one flop, so they never disagree
	assign irq_out = irq_pending;

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always_comb
	begin
		unique case (mgmt.addr)
			REG_STATUS_SUMMARY:
				mgmt.rdata = status_summary;
			REG_INTERRUPT_CTRL_STAT:
				mgmt.rdata = {irq_ctrl, 4'h0, change_flags, irq_pending};
			REG_AUX_MODE_TWO:
				mgmt.rdata = aux_mode_two;
			default:
				mgmt.rdata = 16'h0000;
		endcase
	end

endmodule

//--- test/psir_monitor.sv
`timescale 1ns/1ps
module psir_monitor
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic irq_out,
	input wire logic duplex_full,
	input wire logic speed_100,
	input wire logic tx_en,
	input wire logic is_10bt_half,
	input wire logic rx_dv_raw,
	input wire logic crs_raw,
	input wire logic tx_clk_in,
	input wire logic legacy_partner,
	input wire logic pd_link_raw,
	input wire logic pd_speed_100,
	input wire logic adv_10,
	input wire logic adv_100,
	input wire logic an_link_raw,
	input wire logic rx_dv,
	input wire logic crs,
	input wire logic txc_out,
	input wire logic link_ok
);
	// ----------------------------------------
	// Cycles since each cause; reset counts as a cause so outputs may settle
	// ----------------------------------------
	logic [3:0] s_mdc;
	logic [3:0] s_txc;
	logic [3:0] s_chg;

	function automatic logic [3:0] age(input logic hit, input logic [3:0] n);
		return hit ? 4'h0 : n + {3'h0, n != 4'hf};
	endfunction

	always_ff @(posedge clk_sys)
	begin
		s_mdc <= age(sys_rst || $rose(mdc), s_mdc);
		s_txc <= age(sys_rst || $changed(tx_clk_in), s_txc);
		s_chg <= age(sys_rst || $changed({duplex_full, speed_100, link_ok}), s_chg);
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_irq_cause:
		assert property ($rose(irq_out) |-> s_chg <= 4'h5 || s_mdc <= 4'ha) else $error("irq rose uncaused");
	a_irq_clear:
		assert property ($fell(irq_out) |-> s_mdc <= 4'hc) else $error("irq fell outside access");
	a_rx_source:
		assert property (rx_dv && !$past(sys_rst) |-> $past(rx_dv_raw) || $past(tx_en && is_10bt_half))
			else $error("rx_dv without source");
	a_crs_quiet:
		assert property (!$past(sys_rst) && !$past(tx_en) && !$past(crs_raw) |-> !crs)
			else $error("crs without carrier");
	a_link_source:
		assert property (link_ok |-> ($past(legacy_partner) ? $past(pd_link_raw) : $past(an_link_raw)))
			else $error("link without source");
	a_link_advert:
		assert property (!$past(sys_rst) && $past(legacy_partner && pd_link_raw
			&& (pd_speed_100 ? adv_100 : adv_10)) |-> link_ok) else $error("advertised link refused");
	a_reset_quiet:
		assert property (disable iff (1'h0) sys_rst |=> !irq_out && !link_ok && !mdio_oe && !crs)
			else $error("outputs active after reset");
	a_mdio_stands:
		assert property ($changed(mdio_out) || $changed(mdio_oe) |-> s_mdc <= 4'h7)
			else $error("mdio moved between clock edges");
	a_txc_follow:
		assert property ($changed(txc_out) |-> s_txc <= 4'h6 || s_mdc <= 4'ha)
			else $error("txc moved uncaused");
endmodule

//--- test/psir_mdio_master.sv
`timescale 1ns/1ps
module psir_mdio_master
#(
	parameter logic [4:0] PHY = 5'h01
)
(
	input  wire logic clk_sys,
	input  wire logic mdio_line,
	output logic      mdc,
	output logic      m_out,
	output logic      m_oe
);
	initial
	begin
		mdc = 1'h0;
		m_out = 1'h1;
		m_oe = 1'h0;
	end

	// Slow management clock, 10 system clocks low and 11 high per bit; data sampled just before each of the last 16 rises
	task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] q);
		logic [63:0] f;
		f = {32'hffff_ffff, 2'h1, rd ? 2'h2 : 2'h1, PHY, ra, 2'h2, wd};
		q = 16'h0;
		for (int i = 0; i < 64; i++)
		begin
			@(negedge clk_sys);
			mdc = 1'h0;
			m_oe = !(rd && i > 45);
			m_out = f[63 - i];
			repeat (10) @(negedge clk_sys);
			if (i > 47)
				q = {q[14:0], mdio_line};
			mdc = 1'h1;
			repeat (10) @(negedge clk_sys);
		end
		mdc = 1'h0;
		m_oe = 1'h0;
		repeat (10) @(negedge clk_sys);
	endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench
	import psir_pkg::*;
();
	logic       clk_sys = 1'h0;
	logic       sys_rst = 1'h1;
	logic       mdc, m_out, m_oe, mdio_out, mdio_oe, irq_out, rx_dv, crs, txc_out, link_ok;
	logic       autoneg_enable_pin = 1'h0, an_enable_ctrl = 1'h0, an_complete = 1'h0;
	logic       an_ack_complete_evt = 1'h0, an_ack_detect_evt = 1'h0, an_ability_evt = 1'h0;
	logic       pd_fault_evt = 1'h0, page_rx_evt = 1'h0, jabber_evt = 1'h0, an_pause = 1'h0;
	logic       lp_remote_fault = 1'h0, lp_an_able = 1'h0, speed_100 = 1'h0, duplex_full = 1'h0;
	logic       is_10bt_half = 1'h0, tx_en = 1'h0, rx_dv_raw = 1'h0, rx_partial_nibble = 1'h0;
	logic       crs_raw = 1'h0, tx_clk_in = 1'h0, adv_10 = 1'h0, adv_100 = 1'h0;
	logic       legacy_partner = 1'h0, pd_link_raw = 1'h0, pd_speed_100 = 1'h0, an_link_raw = 1'h0;
	logic [2:0] negotiated_best_mode = 3'h0;
	int         err_total = 0;
	int         total_checks = 0;
	// Pull-up on the shared management line
	wire        mdio_in = mdio_oe ? mdio_out : (m_oe ? m_out : 1'h1);

	always #20 clk_sys = ~clk_sys;

	psir_top i_dut
	(
		.clk_sys, .sys_rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .irq_out, .autoneg_enable_pin,
		.an_enable_ctrl, .an_complete, .an_ack_complete_evt, .an_ack_detect_evt, .an_ability_evt,
		.an_pause, .negotiated_best_mode, .pd_fault_evt, .lp_remote_fault, .page_rx_evt,
		.lp_an_able, .jabber_evt, .speed_100, .duplex_full, .is_10bt_half, .tx_en, .rx_dv_raw,
		.rx_partial_nibble, .crs_raw, .tx_clk_in, .legacy_partner, .pd_link_raw, .pd_speed_100,
		.adv_10, .adv_100, .an_link_raw, .rx_dv, .crs, .txc_out, .link_ok
	);

	psir_mdio_master i_mgmt (.clk_sys, .mdio_line(mdio_in), .mdc, .m_out, .m_oe);

	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected word at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] a, output logic [15:0] q);
		i_mgmt.xfer(1'h1, a, 16'h0, q);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] q;
		i_mgmt.xfer(1'h0, a, d, q);
	endtask

	task automatic chk(input logic [4:0] a, input logic [15:0] e);
		logic [15:0] q;
		rd(a, q);
		cmp_word(q, e);
	endtask

	task automatic t_defaults;
		chk(REG_INTERRUPT_CTRL_STAT, 16'h0f00);
		chk(REG_AUX_MODE_TWO, 16'h008a);
		chk(5'h1c, 16'hffff);
		wr(REG_AUX_MODE_TWO, 16'h0988);
		chk(REG_AUX_MODE_TWO, 16'h0988);
		wr(REG_AUX_MODE_TWO, 16'h008a);
		$display("defaults test done");
	endtask

	task automatic t_summary;
		logic [15:0] q;
		{an_complete, an_pause, lp_remote_fault, lp_an_able, speed_100} = 5'h1f;
		{autoneg_enable_pin, an_enable_ctrl, an_link_raw} = 3'h7;
		negotiated_best_mode = 3'h5;
		{an_ack_complete_evt, an_ack_detect_evt, an_ability_evt} = 3'h7;
		{pd_fault_evt, page_rx_evt, jabber_evt} = 3'h7;
		w(1);
		{an_ack_complete_evt, an_ack_detect_evt, an_ability_evt} = 3'h0;
		{pd_fault_evt, page_rx_evt, jabber_evt} = 3'h0;
		chk(REG_STATUS_SUMMARY, 16'hfdfb);
		chk(REG_STATUS_SUMMARY, 16'h8d5e);
		an_link_raw = 1'h0;
		w(3);
		an_link_raw = 1'h1;
		w(3);
		chk(REG_STATUS_SUMMARY, 16'h8d5a);
		chk(REG_STATUS_SUMMARY, 16'h8d5e);
		for (int m = 0; m < 6; m++)
		begin
			negotiated_best_mode = m[2:0];
			an_enable_ctrl = m[0];
			autoneg_enable_pin = m[1];
			rd(REG_STATUS_SUMMARY, q);
			cmp_word({12'h0, q[10:8], q[1]}, {12'h0, m[2:0], m[1] & m[0]});
		end
		$display("summary test done");
	endtask

	task automatic t_irq;
		wr(REG_INTERRUPT_CTRL_STAT, 16'h4000);
		speed_100 = !speed_100;
		w(6);
		cmp_bit(irq_out, 1'h1);
		chk(REG_INTERRUPT_CTRL_STAT, 16'h4005);
		cmp_bit(irq_out, 1'h0);
		wr(REG_INTERRUPT_CTRL_STAT, 16'h4400);
		speed_100 = !speed_100;
		w(6);
		cmp_bit(irq_out, 1'h0);
		chk(REG_INTERRUPT_CTRL_STAT, 16'h4400);
		wr(REG_INTERRUPT_CTRL_STAT, 16'h4100);
		duplex_full = !duplex_full;
		w(6);
		cmp_bit(irq_out, 1'h0);
		chk(REG_INTERRUPT_CTRL_STAT, 16'h4108);
		wr(REG_INTERRUPT_CTRL_STAT, 16'h4000);
		an_link_raw = 1'h0;
		w(6);
		chk(REG_INTERRUPT_CTRL_STAT, 16'h4003);
		wr(REG_INTERRUPT_CTRL_STAT, 16'h0000);
		an_link_raw = 1'h1;
		w(6);
		chk(REG_INTERRUPT_CTRL_STAT, 16'h0000);
		cmp_bit(irq_out, 1'h0);
		$display("interrupt test done");
	endtask

	task automatic t_data;
		{is_10bt_half, tx_en, crs_raw} = 3'h7;
		w(3);
		cmp_bit(rx_dv, 1'h0);
		cmp_bit(crs, 1'h1);
		tx_en = 1'h0;
		w(2);
		cmp_bit(crs, 1'h0);
		crs_raw = 1'h0;
		wr(REG_AUX_MODE_TWO, 16'h0008);
		tx_en = 1'h1;
		w(3);
		cmp_bit(rx_dv, 1'h1);
		tx_en = 1'h0;
		wr(REG_AUX_MODE_TWO, 16'h0808);
		{rx_dv_raw, rx_partial_nibble} = 2'h3;
		w(3);
		cmp_bit(rx_dv, 1'h0);
		rx_partial_nibble = 1'h0;
		w(3);
		cmp_bit(rx_dv, 1'h1);
		{rx_dv_raw, is_10bt_half, tx_clk_in} = 3'h1;
		w(6);
		cmp_bit(txc_out, 1'h1);
		wr(REG_AUX_MODE_TWO, 16'h0108);
		cmp_bit(txc_out, 1'h0);
		{legacy_partner, pd_link_raw, pd_speed_100, an_link_raw} = 4'he;
		w(3);
		cmp_bit(link_ok, 1'h1);
		wr(REG_AUX_MODE_TWO, 16'h000a);
		cmp_bit(link_ok, 1'h0);
		adv_100 = 1'h1;
		w(3);
		cmp_bit(link_ok, 1'h1);
		$display("datapath test done");
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (90000) @(posedge clk_sys);
		err_total++;
		end_sim;
	end

	initial
	begin
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'h0;
		w(4);
		t_defaults;
		t_summary;
		t_irq;
		t_data;
		end_sim;
	end
endmodule

bind psir_top psir_monitor i_mon
(
	.clk_sys, .sys_rst, .mdc, .mdio_out, .mdio_oe, .irq_out, .duplex_full, .speed_100, .tx_en,
	.is_10bt_half, .rx_dv_raw, .crs_raw, .tx_clk_in, .legacy_partner, .pd_link_raw, .pd_speed_100,
	.adv_10, .adv_100, .an_link_raw, .rx_dv, .crs, .txc_out, .link_ok
);
